// ===== include/group_select_pkg.sv
// Constants and types for the parameter-set selector
// =============================================================
// Behaviour
// - Up to eight sets, exactly one active
// - Only set one enabled: stay idle there
// - Two or more enabled: requests choose set
// - One request input per parameter set
// - Force enable: written group number selects set
// - Force enable ignores automatic request selection
// - Requests may be pulses or held levels
// - Simultaneous requests: highest priority wins
// - Group one highest, group eight lowest
// - Two held levels: higher priority active
// - Pulse-selected group stays latched until changed
// - Held level blocks lower-priority requests
// - Remote write cannot beat higher held group
package group_select_pkg;
   localparam int          GROUP_COUNT  = 8;
   localparam int          INDEX_WIDTH  = 3;
   localparam int          COUNT_WIDTH  = 4;
   localparam logic [7:0]  ACTIVE_RESET = 8'h01;
   localparam logic [3:0]  COUNT_RESET  = 4'h1;
   localparam logic [3:0]  FORCE_NONE   = 4'h0;
endpackage

// ===== hdl/group_priority_pick.sv
// Fixed-priority picker: lowest index set bit becomes one-hot
`timescale 1ns/10ps
module group_priority_pick #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] req,
   output logic      [WIDTH-1:0] grant,
   output logic                  any
);
   logic [WIDTH:0] seen;

   assign seen[0] = 1'b0;

   // Bit 0 is group one, the highest priority
   generate
      for (genvar i = 0; i < WIDTH; i++) begin : g_pick
         assign grant[i]  = req[i] & ~seen[i];
         assign seen[i+1] = seen[i] | req[i];
      end
   endgenerate

   assign any = seen[WIDTH];
endmodule

// ===== hdl/setting_group_selector.sv
// Setting group selector: priority resolution, latching and operator override
`timescale 1ns/10ps
module setting_group_selector
   import group_select_pkg::*;
#(
   parameter int GROUPS = GROUP_COUNT
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire logic [COUNT_WIDTH-1:0] enabled_group_count,
   input  wire logic                   force_override_enable,
   input  wire logic [COUNT_WIDTH-1:0] forced_group_select,
   input  wire logic [GROUPS-1:0]      group_request,
   output logic      [GROUPS-1:0]      active_group,
   output logic      [GROUPS-1:0]      held_group,
   output logic                        selector_idle
);
   // =============================================================
   // Request qualification
   // =============================================================
   logic [GROUPS-1:0] enabled_mask;
   logic [GROUPS-1:0] req_valid;
   logic [GROUPS-1:0] req_prev_reg;
   logic [GROUPS-1:0] held_now;
   logic [GROUPS-1:0] pick_grant;
   logic              pick_any;
   logic [GROUPS-1:0] held_grant;
   logic              held_any;
   logic [GROUPS-1:0] block_mask;
   logic [GROUPS-1:0] force_onehot;
   logic              force_valid;
   logic              force_allowed;
   logic              multi_enabled;
   logic [GROUPS-1:0] active_reg;
   logic [GROUPS-1:0] active_next;
   logic [GROUPS-1:0] held_reg;
   logic              idle_reg;

   generate
      for (genvar g = 0; g < GROUPS; g++) begin : g_group
         // Group beyond the enabled count never requests
         assign enabled_mask[g] = (COUNT_WIDTH'(g) < enabled_group_count);
         assign force_onehot[g] = (forced_group_select == COUNT_WIDTH'(g + 1));
         // Level seen on two consecutive edges counts as held
         assign held_now[g]     = req_valid[g] & req_prev_reg[g];
      end
   endgenerate

   assign req_valid     = group_request & enabled_mask;
   assign multi_enabled = (enabled_group_count > COUNT_RESET);

   group_priority_pick #(.WIDTH(GROUPS)) u_req_pick (
      .req   (req_valid),
      .grant (pick_grant),
      .any   (pick_any)
   );

   group_priority_pick #(.WIDTH(GROUPS)) u_held_pick (
      .req   (held_now),
      .grant (held_grant),
      .any   (held_any)
   );

   // Every group at or below the top held level is blocked
   assign block_mask    = held_any ? ~(held_grant - GROUPS'(1)) : '0;
   assign force_valid   = |(force_onehot & enabled_mask);
   assign force_allowed = force_valid & ~|(force_onehot & block_mask & ~held_grant);

   // =============================================================
   // Next active group
   // =============================================================
   always_comb begin
      active_next = active_reg;
      if (!multi_enabled) begin
         active_next = ACTIVE_RESET[GROUPS-1:0];
      end else if (force_override_enable) begin
         if (force_allowed) begin
            active_next = force_onehot;
         end
      end else if (pick_any) begin
         active_next = pick_grant;
      end else if (~|(active_reg & enabled_mask)) begin
         // Count reduced under a latched group: fall back to group one
         active_next = ACTIVE_RESET[GROUPS-1:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         active_reg   <= ACTIVE_RESET[GROUPS-1:0];
         req_prev_reg <= '0;
         held_reg     <= '0;
         idle_reg     <= 1'b1;
      end else begin
         active_reg   <= active_next;
         req_prev_reg <= req_valid;
         held_reg     <= held_now;
         idle_reg     <= ~multi_enabled;
      end
   end

   assign active_group  = active_reg;
   assign held_group    = held_reg;
   assign selector_idle = idle_reg;

   // =============================================================
   // Checks
   // =============================================================
   logic [GROUPS-1:0] lower_than_held;
   logic [GROUPS-1:0] req_rise;
   logic              force_to_lower;
   logic              force_to_held;
   logic              active_enabled;

   // Groups strictly below the top held level
   assign lower_than_held = block_mask & ~held_grant;
   assign req_rise        = req_valid & ~req_prev_reg;
   assign force_to_lower  = |(force_onehot & lower_than_held);
   assign force_to_held   = |(force_onehot & held_grant);
   assign active_enabled  = |(active_reg & enabled_mask);

   property p_onehot;
      @(posedge core_clk) disable iff (rst) $onehot(active_reg);
   endproperty
   a_onehot: assert property (p_onehot) else $error("active group not one-hot");

   property p_idle_first;
      @(posedge core_clk) disable iff (rst)
         (enabled_group_count <= COUNT_RESET) |=> (active_reg == ACTIVE_RESET[GROUPS-1:0]);
   endproperty
   a_idle_first: assert property (p_idle_first) else $error("single set not active");

   property p_auto_pick;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && !force_override_enable && (req_valid != '0))
         |=> (active_reg == $past(pick_grant));
   endproperty
   a_auto_pick: assert property (p_auto_pick) else $error("highest request not taken");

   property p_force;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && force_override_enable && force_allowed) |=> (active_reg == $past(force_onehot));
   endproperty
   a_force: assert property (p_force) else $error("forced group not taken");

   property p_force_ignores;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && force_override_enable && !force_allowed) |=> $stable(active_reg);
   endproperty
   a_force_ignores: assert property (p_force_ignores) else $error("requests acted under force");

   property p_top_priority;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && !force_override_enable && req_valid[0]) |=> active_reg[0];
   endproperty
   a_top_priority: assert property (p_top_priority) else $error("group one not preferred");

   property p_latch;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && !force_override_enable && (req_valid == '0) && |(active_reg & enabled_mask))
         |=> $stable(active_reg);
   endproperty
   a_latch: assert property (p_latch) else $error("latched group dropped");

   property p_held_blocks;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && !force_override_enable && held_any)
         |=> ((active_reg & $past(lower_than_held)) == '0);
   endproperty
   a_held_blocks: assert property (p_held_blocks) else $error("lower request beat held level");

   property p_beyond_count;
      @(posedge core_clk) disable iff (rst)
         ((active_reg & ~enabled_mask) == '0) ##1 ((enabled_group_count == $past(enabled_group_count)))
         |-> ((active_reg & ~enabled_mask) == '0);
   endproperty
   a_beyond_count: assert property (p_beyond_count) else $error("disabled group active");

   property p_held_out;
      @(posedge core_clk) disable iff (rst)
         1'b1 |=> (held_reg == $past(held_now));
   endproperty
   a_held_out: assert property (p_held_out) else $error("held output not registered");

   property p_req_prev;
      @(posedge core_clk) disable iff (rst)
         1'b1 |=> (req_prev_reg == $past(req_valid));
   endproperty
   a_req_prev: assert property (p_req_prev) else $error("request history lost");

   property p_idle_out;
      @(posedge core_clk) disable iff (rst)
         1'b1 |=> (idle_reg == !$past(multi_enabled));
   endproperty
   a_idle_out: assert property (p_idle_out) else $error("idle flag wrong");

   property p_idle_active;
      @(posedge core_clk) disable iff (rst)
         idle_reg |-> (active_reg == ACTIVE_RESET[GROUPS-1:0]);
   endproperty
   a_idle_active: assert property (p_idle_active) else $error("idle without set one");

   property p_idle_ignores;
      @(posedge core_clk) disable iff (rst)
         (!multi_enabled && (group_request != '0)) |=> (active_reg == ACTIVE_RESET[GROUPS-1:0]);
   endproperty
   a_idle_ignores: assert property (p_idle_ignores) else $error("request acted while idle");

   property p_held_top;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && !force_override_enable && held_any && (req_valid == held_now))
         |=> (active_reg == $past(held_grant));
   endproperty
   a_held_top: assert property (p_held_top) else $error("higher held level not active");

   property p_held_sub;
      @(posedge core_clk) disable iff (rst)
         (held_now & ~req_valid) == '0;
   endproperty
   a_held_sub: assert property (p_held_sub) else $error("held without request");

   property p_pick_onehot;
      @(posedge core_clk) disable iff (rst)
         $onehot0(pick_grant) && (pick_any == (req_valid != '0));
   endproperty
   a_pick_onehot: assert property (p_pick_onehot) else $error("picker grant malformed");

   property p_lowest_loses;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && !force_override_enable && req_valid[GROUPS-1] && (req_valid[GROUPS-2:0] != '0))
         |=> !active_reg[GROUPS-1];
   endproperty
   a_lowest_loses: assert property (p_lowest_loses) else $error("lowest group beat another");

   property p_pulse_taken;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && !force_override_enable && ((pick_grant & req_rise) != '0))
         |=> (active_reg == $past(pick_grant));
   endproperty
   a_pulse_taken: assert property (p_pulse_taken) else $error("pulse request not taken");

   property p_auto_moves;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && !force_override_enable && pick_any && (pick_grant != active_reg))
         |=> (active_reg != $past(active_reg));
   endproperty
   a_auto_moves: assert property (p_auto_moves) else $error("request did not change set");

   property p_fallback;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && !force_override_enable && !pick_any && !active_enabled)
         |=> (active_reg == ACTIVE_RESET[GROUPS-1:0]);
   endproperty
   a_fallback: assert property (p_fallback) else $error("no fallback to set one");

   property p_disabled_ignored;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && !force_override_enable && !pick_any && (group_request != '0) && active_enabled)
         |=> $stable(active_reg);
   endproperty
   a_disabled_ignored: assert property (p_disabled_ignored) else $error("disabled request acted");

   property p_force_free;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && force_override_enable && force_valid && !held_any)
         |=> (active_reg == $past(force_onehot));
   endproperty
   a_force_free: assert property (p_force_free) else $error("free force not taken");

   property p_force_zero;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && force_override_enable && (forced_group_select == FORCE_NONE)) |=> $stable(active_reg);
   endproperty
   a_force_zero: assert property (p_force_zero) else $error("empty force moved set");

   property p_force_invalid;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && force_override_enable && !force_valid) |=> $stable(active_reg);
   endproperty
   a_force_invalid: assert property (p_force_invalid) else $error("disabled force taken");

   property p_force_lower;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && force_override_enable && force_to_lower) |=> $stable(active_reg);
   endproperty
   a_force_lower: assert property (p_force_lower) else $error("force beat held level");

   property p_force_held_ok;
      @(posedge core_clk) disable iff (rst)
         (multi_enabled && force_override_enable && force_valid && force_to_held)
         |=> (active_reg == $past(force_onehot));
   endproperty
   a_force_held_ok: assert property (p_force_held_ok) else $error("force to held set refused");

   property p_force_release;
      @(posedge core_clk) disable iff (rst)
         ($fell(force_override_enable) && multi_enabled && !pick_any && active_enabled)
         |=> $stable(active_reg);
   endproperty
   a_force_release: assert property (p_force_release) else $error("forced set lost on release");

   c_pulse_latch: cover property (@(posedge core_clk) disable iff (rst)
      (multi_enabled && req_valid[2] && !req_prev_reg[2]) ##1 (req_valid == '0) ##2 active_reg[2]);
   c_held_two: cover property (@(posedge core_clk) disable iff (rst) held_now[0] && held_now[1]);
   c_force_move: cover property (@(posedge core_clk) disable iff (rst)
      force_override_enable && force_allowed && (force_onehot != active_reg));
   c_force_refused: cover property (@(posedge core_clk) disable iff (rst)
      force_override_enable && force_valid && !force_allowed);
   c_fallback: cover property (@(posedge core_clk) disable iff (rst)
      multi_enabled && !force_override_enable && !pick_any && !active_enabled);
endmodule

// ===== dv/group_request_source.sv
// Request source model: internal logic and panel lines per group
`timescale 1ns/10ps
module group_request_source (
   input  wire logic [7:0] pulse_req,
   input  wire logic [7:0] hold_req,
   output logic      [7:0] group_request
);
   // One line per group; a pulse and a held level share it
   assign group_request = pulse_req | hold_req;
endmodule

// ===== dv/setting_group_selector_bench.sv
// Self-checking bench for the setting group selector
`timescale 1ns/10ps
module setting_group_selector_bench;
   import group_select_pkg::*;
   logic                   core_clk;
   logic                   rst;
   logic [COUNT_WIDTH-1:0] enabled_group_count;
   logic                   force_override_enable;
   logic [COUNT_WIDTH-1:0] forced_group_select;
   logic [7:0]             pulse_req;
   logic [7:0]             hold_req;
   logic [7:0]             group_request;
   logic [7:0]             active_group;
   logic [7:0]             held_group;
   logic                   selector_idle;
   int                     err_count = 0;
   int                     n_checks = 0;
   int                     cycles = 0;

   group_request_source u_group_request_source (
      .pulse_req     (pulse_req),
      .hold_req      (hold_req),
      .group_request (group_request)
   );
   setting_group_selector u_setting_group_selector (
      .core_clk              (core_clk),
      .rst                   (rst),
      .enabled_group_count   (enabled_group_count),
      .force_override_enable (force_override_enable),
      .forced_group_select   (forced_group_select),
      .group_request         (group_request),
      .active_group          (active_group),
      .held_group            (held_group),
      .selector_idle         (selector_idle)
   );

   // =============================================================
   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Whole sequence needs well under 200 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles > 2000) begin
         err_count++;
         finish_test();
      end
   end

   // =============================================================
   // Tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One-cycle pulse, then one idle cycle so the latch is seen
   task automatic pulse(input logic [7:0] r);
      pulse_req = r;
      @(negedge core_clk);
      pulse_req = 8'h00;
      @(negedge core_clk);
   endtask
   task automatic finish_test;
      $display("errors %0d checks %0d", err_count, n_checks);
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // =============================================================
   // Sequence
   initial begin
      rst = 1'b1;
      enabled_group_count = COUNT_RESET;
      force_override_enable = 1'b0;
      forced_group_select = FORCE_NONE;
      pulse_req = 8'h00;
      hold_req = 8'h00;
      repeat (20) @(negedge core_clk);
      chk(active_group, ACTIVE_RESET);
      chk({7'h00, selector_idle}, 8'h01);
      rst = 1'b0;
      pulse(8'h04);
      chk(active_group, 8'h01);
      enabled_group_count = 4'h4;
      pulse(8'h04);
      chk(active_group, 8'h04);
      chk({7'h00, selector_idle}, 8'h00);
      pulse(8'h0A);
      chk(active_group, 8'h02);
      pulse(8'h10);
      chk(active_group, 8'h02);
      pulse(8'h08);
      chk(active_group, 8'h08);
      hold_req = 8'h0A;
      repeat (3) @(negedge core_clk);
      chk(active_group, 8'h02);
      chk(held_group, 8'h0A);
      pulse(8'h04);
      chk(active_group, 8'h02);
      force_override_enable = 1'b1;
      forced_group_select = 4'h3;
      repeat (2) @(negedge core_clk);
      chk(active_group, 8'h02);
      hold_req = 8'h00;
      repeat (3) @(negedge core_clk);
      chk(active_group, 8'h04);
      pulse(8'h01);
      chk(active_group, 8'h04);
      force_override_enable = 1'b0;
      forced_group_select = FORCE_NONE;
      @(negedge core_clk);
      chk(active_group, 8'h04);
      pulse(8'h01);
      chk(active_group, 8'h01);
      force_override_enable = 1'b1;
      pulse(8'h02);
      chk(active_group, 8'h01);
      forced_group_select = 4'h6;
      pulse(8'h02);
      chk(active_group, 8'h01);
      hold_req = 8'h04;
      forced_group_select = 4'h3;
      repeat (3) @(negedge core_clk);
      chk(active_group, 8'h04);
      forced_group_select = 4'h2;
      repeat (2) @(negedge core_clk);
      chk(active_group, 8'h02);
      forced_group_select = 4'h4;
      repeat (2) @(negedge core_clk);
      chk(active_group, 8'h02);
      force_override_enable = 1'b0;
      forced_group_select = FORCE_NONE;
      repeat (2) @(negedge core_clk);
      chk(active_group, 8'h04);
      hold_req = 8'h00;
      enabled_group_count = 4'h2;
      repeat (2) @(negedge core_clk);
      chk(active_group, 8'h01);
      enabled_group_count = 4'h0;
      pulse(8'h02);
      chk(active_group, 8'h01);
      chk({7'h00, selector_idle}, 8'h01);
      enabled_group_count = 4'h8;
      pulse(8'h80);
      chk(active_group, 8'h80);
      pulse(8'hC0);
      chk(active_group, 8'h40);
      finish_test();
   end
endmodule
